// File: verilog/icr_consts.svh
// Constants for the I2C control-register-one block.
// Assumes inclusion by bare name from the design modules.
`ifndef ICR_CONSTS_SVH
`define ICR_CONSTS_SVH

// Register word indices on the AHB-Lite slave, decoded from address bits 4:2.
`define ICR_OFS_CTRL_ONE 3'h0
`define ICR_OFS_CTRL_TWO 3'h1
`define ICR_OFS_CLK_REG 3'h2
`define ICR_OFS_ACK_CTRL 3'h3
`define ICR_OFS_DATA 3'h4
`define ICR_OFS_STATUS 3'h5
`define ICR_OFS_PORT 3'h6
`define ICR_OFS_PINS 3'h7

// Field positions inside the control registers.
`define ICR_B_STOP_IRQ_EN 0
`define ICR_B_RX_IRQ_EN 1
`define ICR_B_SDA_OVR 2
`define ICR_B_SCL_OVR 3
`define ICR_B_SDA_MON 4
`define ICR_B_SCL_MON 5
`define ICR_B_CK_LO 6
`define ICR_B_CK_HI_LSB 3
`define ICR_B_SRC_SEL 0
`define ICR_B_STOP_IN_WAIT 1
`define ICR_B_ACK_VAL 0
`define ICR_B_ACK_CLK_EN 1
`define ICR_B_IF_EN 0
`define ICR_B_TX_MODE 1
`define ICR_B_PENDING 4
`define ICR_B_BUSY 5

// Reset values.
`define ICR_RST_PENDING 1'b1
`define ICR_RST_CTRL 1'b0

// Bit counts of a byte on the wire.
`define ICR_LAST_DATA_BIT 4'h7
`define ICR_ACK_BIT 4'h8

`endif

// File: verilog/icr_pkg.sv
// Types shared by the I2C control-register-one block.
// Assumes nothing of its surroundings.
package icr_pkg;
    typedef enum logic [1:0] {
        ICR_HT_IDLE = 2'b00,
        ICR_HT_BUSY = 2'b01,
        ICR_HT_NONSEQ = 2'b10,
        ICR_HT_SEQ = 2'b11
    } icr_htrans_t;
    typedef logic [7:0] icr_byte_t;
    typedef logic [4:0] icr_clk_sel_t;
endpackage

// File: verilog/icr_clk_div.sv
// Fractional divider making the interface system clock tick.
// Assumes a select code from software and a run gate from power control.
`timescale 1ns/1ps
module icr_clk_div #(
    parameter int ACC_W = 5
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire icr_pkg::icr_clk_sel_t sel_in,
    input wire logic half_src_in,
    input wire logic run_in,
    output logic tick_out
);
    if (ACC_W < 5) begin : g_bad_width
        $error("icr_clk_div needs ACC_W of at least 5");
    end

    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] acc_d;
    logic [ACC_W-1:0] thr;
    logic [ACC_W-1:0] step;
    logic [ACC_W-1:0] sum;
    logic tick_d;

    // Threshold in half source periods, one per divider code.
    always_comb begin
        thr = ACC_W'(4);
        unique casez (sel_in)
            5'b00000: thr = ACC_W'(4); // [R13]
            5'b00001: thr = ACC_W'(8); // [R13]
            5'b00010: thr = ACC_W'(16); // [R13]
            5'b001??: thr = ACC_W'(5); // [R13]
            5'b010??: thr = ACC_W'(6); // [R13]
            5'b011??: thr = ACC_W'(10); // [R13]
            5'b100??: thr = ACC_W'(12); // [R13]
            default: thr = ACC_W'(4);
        endcase
    end

    assign step = half_src_in ? ACC_W'(1) : ACC_W'(2); // [R15]
    assign sum = acc_q + step;
    assign tick_d = run_in & (sum >= thr); // [R17]
    assign acc_d = !run_in ? acc_q : (tick_d ? sum - thr : sum);

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            acc_q <= '0;
            tick_out <= 1'b0;
        end else begin
            acc_q <= acc_d;
            tick_out <= tick_d;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    div_two_a: assert property ( // [R13]
        (sel_in == 5'h00 && !half_src_in && run_in && tick_out)
        ##1 (sel_in == 5'h00 && !half_src_in && run_in) |=> tick_out
    ) else $error("divide by two must tick every second cycle");
    div_stop_a: assert property ( // [R17]
        !run_in |=> !tick_out
    ) else $error("divider ticked while clock was not supplied");
endmodule // icr_clk_div

// File: verilog/icr_top.sv
// Control register one of an I2C interface with its byte engine slice.
// Assumes an AHB-Lite master, open-drain pads and power mode inputs.
// Function
// R1: Stop detect raises interrupt when enabled.
// R2: Receive stall at last data bit falling.
// R3: Ack clock falling clears pending, interrupts again.
// R4: Software resumes stall with ack then pending.
// R5: Software resumes ack interrupt by data write.
// R6: Wait flag readable; data sets, ack clears.
// R7: Wait stays zero on transmit, address.
// R8: Software keeps rx enable off without ack clock.
// R9: SDA override outputs port bit.
// R10: SCL override outputs port bit.
// R11: Pin levels always readable.
// R12: Read-only monitors of internal line outputs.
// R13: Five select bits choose divider ratio.
// R14: Software uses only the seven defined codes.
// R15: Source bit selects full or half clock.
// R16: Wait mode with clock kept still receives.
// R17: No operation in stop or low power.
// R18: Ack write sets pending when waiting.
`timescale 1ns/1ps
`include "icr_consts.svh"
module icr_top (
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic HREADY_IN,
    input wire logic [31:0] HWDATA_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    input wire logic SDA_PIN_IN,
    output logic SDA_PIN_OUT,
    output logic SDA_PIN_OE_N_OUT,
    input wire logic SCL_PIN_IN,
    output logic SCL_PIN_OUT,
    output logic SCL_PIN_OE_N_OUT,
    input wire logic WAIT_MODE_IN,
    input wire logic STOP_MODE_IN,
    input wire logic LOW_POWER_IN,
    output logic IRQ_OUT
);
    logic sim_q, wit_q, ped_q, pec_q, src_q, siw_q, ackv_q, ackc_q;
    logic en_q, tx_q, psda_q, pscl_q, pend_q, wait_q, busy_q, first_q;
    logic [4:0] ck_q;
    logic [3:0] cnt_q;
    icr_pkg::icr_byte_t shift_q;
    logic sda_s1_q, sda_s2_q, scl_s1_q, scl_s2_q, sda_t_q, scl_t_q;
    logic wr_q, rd_q;
    logic [2:0] widx_q, ridx_q;
    logic wmap_q, rmap_q;
    logic [31:0] rdata_d;

    // AHB-Lite address phase decode.
    wire logic acc = HSEL_IN & HREADY_IN & HREADYOUT_OUT & HTRANS_IN[1];
    wire logic amap = (HADDR_IN[31:5] == 27'h0000000);
    wire logic [7:0] wd = HWDATA_IN[7:0];
    wire logic wr_c1 = wr_q & wmap_q & (widx_q == `ICR_OFS_CTRL_ONE);
    wire logic wr_c2 = wr_q & wmap_q & (widx_q == `ICR_OFS_CTRL_TWO);
    wire logic wr_ck = wr_q & wmap_q & (widx_q == `ICR_OFS_CLK_REG);
    wire logic wr_ack = wr_q & wmap_q & (widx_q == `ICR_OFS_ACK_CTRL);
    wire logic wr_dat = wr_q & wmap_q & (widx_q == `ICR_OFS_DATA);
    wire logic wr_st = wr_q & wmap_q & (widx_q == `ICR_OFS_STATUS);
    wire logic wr_pt = wr_q & wmap_q & (widx_q == `ICR_OFS_PORT);

    // Clock gating by power mode and the interface clock tick.
    wire logic run = ~STOP_MODE_IN & ~LOW_POWER_IN
        & ~(WAIT_MODE_IN & siw_q); // [R16] [R17]
    logic tk;
    icr_clk_div #(.ACC_W(5)) u_div (
        .clk_in(CLK_IN),
        .resetn_in(RESETN_IN),
        .sel_in(ck_q),
        .half_src_in(src_q),
        .run_in(run),
        .tick_out(tk)
    );

    // Bus condition and clock edge events, sampled on the tick.
    wire logic scl_hi = scl_t_q & scl_s2_q;
    wire logic start_ev = tk & en_q & scl_hi & sda_t_q & ~sda_s2_q;
    wire logic stop_ev = tk & en_q & scl_hi & ~sda_t_q & sda_s2_q;
    wire logic fall_ev = tk & busy_q & scl_t_q & ~scl_s2_q;
    wire logic rise_ev = tk & busy_q & ~scl_t_q & scl_s2_q;
    wire logic rx = ~tx_q;
    wire logic last_fall = fall_ev & (cnt_q == `ICR_LAST_DATA_BIT);
    wire logic ack_fall = fall_ev & (cnt_q == `ICR_ACK_BIT);
    wire logic stall_ev = last_fall & rx & ~first_q & wit_q & ackc_q
        & wait_q; // [R2] [R7]
    wire logic noack_done = last_fall & ~ackc_q;
    wire logic pend_clr = stall_ev | ack_fall | noack_done; // [R3]
    wire logic irq_d = pend_clr | (stop_ev & sim_q); // [R1]
    wire logic byte_end = ack_fall | noack_done;
    wire logic pend_set = ~en_q | wr_dat | (wr_st & wd[`ICR_B_PENDING])
        | (wr_ack & wit_q & wait_q); // [R18]

    // Internal line outputs and pad selection.
    wire logic in_data = cnt_q < `ICR_ACK_BIT;
    wire logic sda_int = ~busy_q ? 1'b1 : (tx_q & in_data) ? shift_q[7]
        : (rx & (cnt_q == `ICR_ACK_BIT)) ? ackv_q : 1'b1;
    wire logic scl_int = ~(busy_q & ~pend_q);
    wire logic sda_o = ped_q ? psda_q : sda_int; // [R9]
    wire logic scl_o = pec_q ? pscl_q : scl_int; // [R10]

    // Read multiplexer.
    wire logic [7:0] rd_c1 = {ck_q[1:0], scl_int, sda_int, pec_q, ped_q,
        wait_q, sim_q}; // [R6] [R12]
    always_comb begin
        rdata_d = 32'h00000000;
        unique case (ridx_q)
            `ICR_OFS_CTRL_ONE: rdata_d[7:0] = rd_c1;
            `ICR_OFS_CTRL_TWO: rdata_d[5:3] = ck_q[4:2];
            `ICR_OFS_CLK_REG: rdata_d[1:0] = {siw_q, src_q};
            `ICR_OFS_ACK_CTRL: rdata_d[1:0] = {ackc_q, ackv_q};
            `ICR_OFS_DATA: rdata_d[7:0] = shift_q;
            `ICR_OFS_STATUS: rdata_d[5:0] = {busy_q, pend_q, 2'b00,
                tx_q, en_q};
            `ICR_OFS_PORT: rdata_d[1:0] = {pscl_q, psda_q};
            `ICR_OFS_PINS: rdata_d[1:0] = {scl_s2_q, sda_s2_q}; // [R11]
        endcase
        if (!rmap_q) begin
            rdata_d = 32'h00000000;
        end
    end

    // Bus slave: writes land in the data phase, reads take one wait state.
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            widx_q <= 3'h0;
            ridx_q <= 3'h0;
            wmap_q <= 1'b0;
            rmap_q <= 1'b0;
            HRDATA_OUT <= 32'h00000000;
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT <= 1'b0;
        end else begin
            wr_q <= acc & HWRITE_IN;
            rd_q <= acc & ~HWRITE_IN;
            if (acc) begin
                widx_q <= HADDR_IN[4:2];
                ridx_q <= HADDR_IN[4:2];
                wmap_q <= amap;
                rmap_q <= amap;
            end
            HREADYOUT_OUT <= ~(acc & ~HWRITE_IN);
            if (rd_q) begin
                HRDATA_OUT <= rdata_d;
            end
        end
    end

    // Software control bits.
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            {sim_q, wit_q, ped_q, pec_q} <= 4'h0;
            ck_q <= 5'h00;
            {src_q, siw_q, ackv_q, ackc_q} <= 4'h0;
            {en_q, tx_q, psda_q, pscl_q} <= 4'h0;
        end else begin
            if (wr_c1) begin
                sim_q <= wd[`ICR_B_STOP_IRQ_EN];
                wit_q <= wd[`ICR_B_RX_IRQ_EN];
                ped_q <= wd[`ICR_B_SDA_OVR];
                pec_q <= wd[`ICR_B_SCL_OVR];
                ck_q[1:0] <= wd[`ICR_B_CK_LO +: 2]; // [R13]
            end
            if (wr_c2) begin
                ck_q[4:2] <= wd[`ICR_B_CK_HI_LSB +: 3]; // [R13]
            end
            if (wr_ck) begin
                src_q <= wd[`ICR_B_SRC_SEL]; // [R15]
                siw_q <= wd[`ICR_B_STOP_IN_WAIT]; // [R16]
            end
            if (wr_ack) begin
                ackv_q <= wd[`ICR_B_ACK_VAL];
                ackc_q <= wd[`ICR_B_ACK_CLK_EN];
            end
            if (wr_st) begin
                en_q <= wd[`ICR_B_IF_EN];
                tx_q <= wd[`ICR_B_TX_MODE];
            end
            if (wr_pt) begin
                {pscl_q, psda_q} <= wd[1:0];
            end
        end
    end

    // Pending bit and wait flag; a hardware clear beats a software set.
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            pend_q <= `ICR_RST_PENDING;
            wait_q <= `ICR_RST_CTRL;
        end else begin
            if (pend_clr & en_q) begin
                pend_q <= 1'b0; // [R2] [R3]
            end else if (pend_set) begin
                pend_q <= 1'b1; // [R18]
            end
            if (start_ev | ~en_q) begin
                wait_q <= 1'b0; // [R7]
            end else if (wr_dat) begin
                wait_q <= rx & ~first_q; // [R6] [R7]
            end else if (wr_ack) begin
                wait_q <= 1'b0; // [R6]
            end
        end
    end

    // Byte engine on the interface clock tick.
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            busy_q <= 1'b0;
            first_q <= 1'b0;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
        end else begin
            if (~en_q | stop_ev | start_ev) begin
                busy_q <= start_ev;
                first_q <= start_ev;
                // The fall that closes a START carries no bit.
                cnt_q <= start_ev ? 4'hf : 4'h0;
            end else if (fall_ev) begin
                cnt_q <= (byte_end) ? 4'h0 : cnt_q + 4'h1;
                first_q <= first_q & ~byte_end;
            end
            if (wr_dat) begin
                shift_q <= wd;
            end else if (rise_ev & rx & in_data) begin
                shift_q <= {shift_q[6:0], sda_s2_q};
            end else if (fall_ev & tx_q & in_data) begin
                shift_q <= {shift_q[6:0], 1'b1};
            end
        end
    end

    // Pin synchronisers, tick samples and registered pad outputs.
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            {sda_s1_q, sda_s2_q, scl_s1_q, scl_s2_q} <= 4'hf;
            {sda_t_q, scl_t_q} <= 2'h3;
            {SDA_PIN_OUT, SCL_PIN_OUT} <= 2'h3;
            {SDA_PIN_OE_N_OUT, SCL_PIN_OE_N_OUT} <= 2'h3;
            IRQ_OUT <= 1'b0;
        end else begin
            {sda_s1_q, sda_s2_q} <= {SDA_PIN_IN, sda_s1_q};
            {scl_s1_q, scl_s2_q} <= {SCL_PIN_IN, scl_s1_q};
            if (tk) begin
                {sda_t_q, scl_t_q} <= {sda_s2_q, scl_s2_q};
            end
            SDA_PIN_OUT <= sda_o;
            SCL_PIN_OUT <= scl_o;
            SDA_PIN_OE_N_OUT <= ~(en_q & ~sda_o); // [R9]
            SCL_PIN_OE_N_OUT <= ~(en_q & ~scl_o); // [R10]
            IRQ_OUT <= irq_d & en_q; // [R1] [R3]
        end
    end

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESETN_IN);

    stop_irq_a: assert property ( // [R1]
        stop_ev && sim_q && en_q |=> IRQ_OUT
    ) else $error("stop detect did not raise interrupt");
    rx_stall_a: assert property ( // [R2]
        stall_ev && en_q && !pec_q
        |=> !pend_q && IRQ_OUT ##1 !SCL_PIN_OE_N_OUT
    ) else $error("receive stall did not hold clock low");
    ack_fall_a: assert property ( // [R3]
        ack_fall && en_q |=> !pend_q && IRQ_OUT
    ) else $error("ack clock falling did not interrupt");
    wait_set_a: assert property ( // [R6]
        wr_dat && en_q && rx && !first_q && !start_ev |=> wait_q
    ) else $error("data write did not set wait flag");
    wait_clr_a: assert property ( // [R6]
        wr_ack |=> !wait_q ##1 ($past(rd_c1[1]) == 1'b0)
    ) else $error("ack write did not clear wait flag");
    wait_tx_a: assert property ( // [R7]
        wr_dat && tx_q |=> !wait_q
    ) else $error("wait flag set during transmit");
    sda_ovr_a: assert property ( // [R9]
        en_q && ped_q |=> SDA_PIN_OUT == $past(psda_q)
    ) else $error("sda override not honoured");
    scl_ovr_a: assert property ( // [R10]
        en_q && pec_q && !pscl_q |=> !SCL_PIN_OE_N_OUT
    ) else $error("scl override not honoured");
    pin_read_a: assert property ( // [R11]
        rd_q && rmap_q && ridx_q == `ICR_OFS_PINS
        |=> HRDATA_OUT[1:0] == $past({scl_s2_q, sda_s2_q})
    ) else $error("pin level read wrong");
    mon_read_a: assert property ( // [R12]
        rd_q && rmap_q && ridx_q == `ICR_OFS_CTRL_ONE
        |=> HRDATA_OUT[5:4] == $past({scl_int, sda_int})
    ) else $error("monitor bits read wrong");
    power_a: assert property ( // [R17]
        STOP_MODE_IN ##1 STOP_MODE_IN ##1 STOP_MODE_IN
        |-> $stable(cnt_q) && $stable(busy_q)
    ) else $error("engine moved without clock");
    ack_pend_a: assert property ( // [R18]
        wr_ack && wit_q && wait_q && !pend_clr |=> pend_q
    ) else $error("ack write did not release stall");

    stall_c: cover property (stall_ev && en_q);
    ack_c: cover property (ack_fall && en_q);
    stop_c: cover property (stop_ev && sim_q);
    resume_c: cover property (stall_ev ##[1:1000] wr_ack ##[1:1000] ack_fall);
endmodule // icr_top

// File: test/icr_i2c_master.sv
// Behavioural I2C bus master facing the block's pins.
// Assumes the bench resolves the open-drain lines with pull-ups.
`timescale 1ns/1ps
module icr_i2c_master #(
    parameter int HALF = 64
) (
    input wire logic clk_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_rel_out,
    output logic sda_rel_out
);
    int stuck_n = 0;
    initial begin
        scl_rel_out = 1'b1;
        sda_rel_out = 1'b1;
    end
    task automatic half_bit();
        repeat (HALF) @(posedge clk_in);
    endtask
    task automatic settle();
        repeat (HALF / 4) @(posedge clk_in);
    endtask
    // Releases SCL and waits a bounded time while the device stretches it.
    task automatic scl_high();
        int n;
        n = 0;
        scl_rel_out <= 1'b1;
        @(posedge clk_in);
        while (scl_in !== 1'b1 && n < 4000) begin
            @(posedge clk_in);
            n++;
        end
        if (n == 4000) stuck_n++;
        half_bit();
    endtask
    task automatic start_cond();
        sda_rel_out <= 1'b0;
        half_bit();
        scl_rel_out <= 1'b0;
        half_bit();
    endtask
    task automatic send_byte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            settle();
            sda_rel_out <= v[i];
            half_bit();
            scl_high();
            scl_rel_out <= 1'b0;
        end
        half_bit();
    endtask
    task automatic ack_clock(output logic seen);
        settle();
        sda_rel_out <= 1'b1;
        half_bit();
        scl_high();
        seen = sda_in;
        scl_rel_out <= 1'b0;
        half_bit();
    endtask
    task automatic stop_cond();
        settle();
        sda_rel_out <= 1'b0;
        half_bit();
        scl_high();
        sda_rel_out <= 1'b1;
        half_bit();
    endtask
endmodule // icr_i2c_master

// File: test/i2c_control_reg_one_test.sv
// Self-checking bench for the I2C control-register-one block.
// Assumes the design files and icr_consts.svh are compiled first.
`timescale 1ns/1ps
`include "icr_consts.svh"
`define CHECK_EQ(what, exp, got) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("mismatch %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module i2c_control_reg_one_test;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic wait_mode = 1'b0;
    logic stop_mode = 1'b0;
    logic low_power = 1'b0;
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp, sda_o, sda_oe_n, scl_o, scl_oe_n, irq;
    wire logic p_scl, p_sda, sda_line, scl_line;
    logic rdy_s;
    logic [31:0] rd_s;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;
    int irq_n = 0;
    assign sda_line = p_sda & (sda_oe_n | sda_o);
    assign scl_line = p_scl & (scl_oe_n | scl_o);
    initial forever #2 clk = ~clk;
    icr_top i_dut (.CLK_IN(clk), .RESETN_IN(resetn), .HSEL_IN(hsel),
        .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
        .HSIZE_IN(3'h2), .HREADY_IN(hreadyout), .HWDATA_IN(hwdata),
        .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hreadyout), .HRESP_OUT(hresp),
        .SDA_PIN_IN(sda_line), .SDA_PIN_OUT(sda_o),
        .SDA_PIN_OE_N_OUT(sda_oe_n), .SCL_PIN_IN(scl_line),
        .SCL_PIN_OUT(scl_o), .SCL_PIN_OE_N_OUT(scl_oe_n),
        .WAIT_MODE_IN(wait_mode), .STOP_MODE_IN(stop_mode),
        .LOW_POWER_IN(low_power), .IRQ_OUT(irq));
    icr_i2c_master #(.HALF(64)) i_master (.clk_in(clk), .scl_in(scl_line),
        .sda_in(sda_line), .scl_rel_out(p_scl), .sda_rel_out(p_sda));
    // Outputs are captured mid-cycle so the master reads them race-free.
    always @(negedge clk) begin
        rdy_s = hreadyout;
        rd_s = hrdata;
    end
    always @(posedge clk) begin
        if (irq === 1'b1) irq_n++;
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            conclude();
        end
    end
    task automatic conclude();
        $display("counts: %0d checks, %0d mismatches", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic bus(input logic [31:0] a, input logic w,
                       input logic [7:0] wd, output logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= icr_pkg::ICR_HT_NONSEQ;
        @(posedge clk);
        while (rdy_s !== 1'b1) @(posedge clk);
        htrans <= icr_pkg::ICR_HT_IDLE;
        hwdata <= {24'h0, wd};
        @(posedge clk);
        while (rdy_s !== 1'b1) @(posedge clk);
        d = rd_s;
    endtask
    task automatic wr(input logic [2:0] idx, input logic [7:0] v);
        logic [31:0] d;
        bus({27'h0, idx, 2'b00}, 1'b1, v, d);
    endtask
    task automatic rd(input logic [2:0] idx, output logic [7:0] v);
        logic [31:0] d;
        bus({27'h0, idx, 2'b00}, 1'b0, 8'h00, d);
        v = d[7:0];
    endtask
    // Control one reads back its enables; bit 1 shows the idle wait flag.
    function automatic logic [7:0] exp_ctrl_one(input logic [7:0] w);
        return w & 8'hcd;
    endfunction
    function automatic logic [4:0] pick_code(input int k);
        logic [4:0] t[7] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h0c, 5'h10};
        return t[k];
    endfunction
    initial begin
        logic [7:0] v, w, b;
        logic [31:0] d;
        logic [4:0] code;
        logic src, seen;
        int base;
        void'($urandom(32'hf1443d81));
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        rd(`ICR_OFS_STATUS, v);
        `CHECK_EQ("status reset", 8'h10, v)
        bus(32'h20, 1'b1, 8'hff, d);
        bus(32'h20, 1'b0, 8'h00, d);
        `CHECK_EQ("unmapped", 32'h0, d)
        `CHECK_EQ("hresp", 1'b0, hresp)
        $display("test reset done");
        repeat (8) begin
            code = pick_code($urandom_range(6));
            src = $urandom_range(1);
            w = $urandom;
            w = {code[1:0], 2'b00, w[3:2], 1'b0, w[0]};
            wr(`ICR_OFS_CTRL_ONE, w);
            wr(`ICR_OFS_CTRL_TWO, {2'b00, code[4:2], 3'b000});
            wr(`ICR_OFS_CLK_REG, {7'h0, src});
            rd(`ICR_OFS_CTRL_ONE, v);
            `CHECK_EQ("ctrl one", exp_ctrl_one(w), v & 8'hcf)
            rd(`ICR_OFS_CTRL_TWO, v);
            `CHECK_EQ("ctrl two", {2'b00, code[4:2], 3'b000}, v & 8'h38)
            rd(`ICR_OFS_CLK_REG, v);
            `CHECK_EQ("clock source", src, v[0])
        end
        $display("test registers done");
        wr(`ICR_OFS_STATUS, 8'h01);
        wr(`ICR_OFS_CTRL_ONE, {code[1:0], 6'h0c});
        for (int p = 0; p < 4; p++) begin
            wr(`ICR_OFS_PORT, p[7:0]);
            repeat (8) @(negedge clk);
            `CHECK_EQ("sda drive", p[0], sda_oe_n)
            `CHECK_EQ("scl drive", p[1], scl_oe_n)
            rd(`ICR_OFS_PINS, v);
            `CHECK_EQ("pins", p[1:0], v[1:0])
        end
        wr(`ICR_OFS_CTRL_ONE, {code[1:0], 6'h00});
        wr(`ICR_OFS_STATUS, 8'h00);
        $display("test override done");
        wr(`ICR_OFS_ACK_CTRL, 8'h02);
        wr(`ICR_OFS_CTRL_ONE, {code[1:0], 6'h03});
        wr(`ICR_OFS_CLK_REG, {7'h0, src});
        wr(`ICR_OFS_STATUS, 8'h01);
        wait_mode <= 1'b1;
        base = irq_n;
        i_master.start_cond();
        i_master.send_byte(8'ha4);
        i_master.ack_clock(seen);
        `CHECK_EQ("address irq", base + 1, irq_n)
        rd(`ICR_OFS_CTRL_ONE, v);
        `CHECK_EQ("wait after address", 1'b0, v[1])
        wait_mode <= 1'b0;
        b = $urandom;
        wr(`ICR_OFS_DATA, 8'h00);
        rd(`ICR_OFS_CTRL_ONE, v);
        `CHECK_EQ("wait set", 1'b1, v[1])
        i_master.send_byte(b);
        `CHECK_EQ("last bit irq", base + 2, irq_n)
        `CHECK_EQ("scl held", 1'b0, scl_oe_n)
        rd(`ICR_OFS_STATUS, v);
        `CHECK_EQ("pending stall", 1'b0, v[4])
        rd(`ICR_OFS_CTRL_ONE, v);
        `CHECK_EQ("scl monitor", 1'b0, v[5])
        rd(`ICR_OFS_DATA, v);
        `CHECK_EQ("received", b, v)
        wr(`ICR_OFS_ACK_CTRL, 8'h02);
        rd(`ICR_OFS_CTRL_ONE, v);
        `CHECK_EQ("wait cleared", 1'b0, v[1])
        rd(`ICR_OFS_STATUS, v);
        `CHECK_EQ("pending set", 1'b1, v[4])
        wr(`ICR_OFS_STATUS, 8'h11);
        i_master.ack_clock(seen);
        `CHECK_EQ("ack level", 1'b0, seen)
        `CHECK_EQ("ack irq", base + 3, irq_n)
        rd(`ICR_OFS_STATUS, v);
        `CHECK_EQ("pending ack", 1'b0, v[4])
        wr(`ICR_OFS_DATA, 8'h00);
        i_master.stop_cond();
        repeat (32) @(posedge clk);
        `CHECK_EQ("stop irq", base + 4, irq_n)
        $display("test receive done");
        for (int m = 0; m < 2; m++) begin
            stop_mode <= (m == 0);
            low_power <= (m == 1);
            base = irq_n;
            i_master.start_cond();
            i_master.send_byte(8'h5a);
            i_master.ack_clock(seen);
            i_master.stop_cond();
            `CHECK_EQ("no irq unpowered", base, irq_n)
        end
        stop_mode <= 1'b0;
        low_power <= 1'b0;
        @(posedge clk);
        `CHECK_EQ("scl released", 0, i_master.stuck_n)
        $display("test power done");
        conclude();
    end
endmodule // i2c_control_reg_one_test
